// [swm_pkg.sv]
// Shared constants and carrier types of the switch mask and mode control block
package swm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  localparam int DW = 8; // Register data width
  localparam int AW = 6; // Register address width
  localparam int BANK_BIT = 4; // Address bit that the bank select ORs into
  // Demultiplexed bus addresses
  localparam logic [5:0] ADR_D_MASK = 6'h0e; // Mask write, status read
  localparam logic [5:0] ADR_D_MODE = 6'h0f;
  // Multiplexed bus addresses
  localparam logic [5:0] ADR_M_MASK = 6'h1c; // Mask write, status read
  localparam logic [5:0] ADR_M_MODE_A = 6'h1e;
  localparam logic [5:0] ADR_M_MODE_B = 6'h3e;
  // Reset and default read values
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_MODE = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  // Status and mask bit of the signaling queue flag
  localparam int SQ_BIT = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Mode field encodings
  typedef enum logic [1:0] {
    MD_CM_RESET = 2'b00,
    MD_TEST = 2'b01,
    MD_INIT = 2'b10,
    MD_NORMAL = 2'b11
  } swm_mode_t;

  // Operation mode register, bit 7 down to bit 0
  typedef struct packed {
    swm_mode_t mode_field;
    logic pcm_standby_bit;
    logic pcm_test_loop_bit;
    logic subscriber_driver_select;
    logic monitor_protocol_select;
    logic subscriber_standby_bit;
    logic bank_select;
  } swm_omr_t;

  ////////////////////////////////////////////////////////////////////////////
  // Memory access timing, figures in tenths of reference clock cycles
  localparam int CLK_NS = 25; // System clock period
  localparam int RCL_NS = 25; // Reference clock period
  localparam int T10_CMR = 2560; // Control memory reset, 256 cycles
  localparam int T10_INIT = 25; // Initialization access, 2.5 cycles max
  localparam int T10_NORM = 95; // Normal single access, 9.5 cycles
  localparam int T10_TRI = 10350; // Tristate field init, 1035 cycles
  localparam int T10_TEST = 20570; // Test mode access, 2057 cycles
  localparam int CW = 12; // Access counter width
  // Longest times round down to whole clock cycles
  localparam logic [CW-1:0] CYC_CMR = CW'((T10_CMR * RCL_NS) / (10 * CLK_NS));
  localparam logic [CW-1:0] CYC_INIT = CW'((T10_INIT * RCL_NS) / (10 * CLK_NS));
  localparam logic [CW-1:0] CYC_NORM = CW'((T10_NORM * RCL_NS) / (10 * CLK_NS));
  localparam logic [CW-1:0] CYC_TRI = CW'((T10_TRI * RCL_NS) / (10 * CLK_NS));
  localparam logic [CW-1:0] CYC_TEST = CW'((T10_TEST * RCL_NS) / (10 * CLK_NS));
  // Interrupt output gap after a mask write
  localparam logic [1:0] INT_GAP_CYC = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Memory constants and carriers
  localparam int CM_AW = 8; // Control memory address width
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0;

  // Register bus request, strobes active low
  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
    logic mux_mode;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } swm_bus_t;

  // Memory access command
  typedef struct packed {
    logic start;
    logic sel;
    logic full_field;
    logic [CM_AW-1:0] addr;
    logic [3:0] code;
    logic [DW-1:0] data;
  } swm_acc_req_t;

  // Memory write port
  typedef struct packed {
    logic we;
    logic sel;
    logic [CM_AW-1:0] addr;
    logic [3:0] code;
    logic [DW-1:0] data;
  } swm_cm_wr_t;

endpackage

// [swm_seq.sv]
// Memory access sequencer: times each access and walks the memory when needed
`timescale 1ns/1ps
module swm_seq #(
  parameter int WALK_LEN = 2 ** swm_pkg::CM_AW
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Command side
  input wire swm_pkg::swm_acc_req_t req,
  input wire swm_pkg::swm_mode_t mode,
  output logic busy,
  output logic done,
  // Memory write port
  output swm_pkg::swm_cm_wr_t wr
);
  import swm_pkg::*;

  // Walk must fit the shortest walking access
  if (WALK_LEN < 1 || WALK_LEN > 2 ** CM_AW || WALK_LEN > int'(CYC_CMR))
  begin : g_chk
    $error("swm_seq: WALK_LEN out of range");
  end

  localparam logic [CM_AW-1:0] WALK_LAST = CM_AW'(WALK_LEN - 1);

  typedef enum logic [0:0] {SQ_IDLE = 1'b0, SQ_RUN = 1'b1} swm_sq_t;

  typedef struct packed {
    swm_sq_t st; // Idle or running
    logic [CW-1:0] cnt; // Cycles left in the access
    logic [CM_AW-1:0] idx; // Walk position
    logic walk; // Access covers every location
    logic wend; // Walk has finished
    logic first; // First running cycle
    logic done; // End of access pulse
    swm_cm_wr_t wr; // Registered write port
  } swm_seq_st_t;

  swm_seq_st_t q, d;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    d.wr.we = 1'b0;
    d.done = 1'b0;
    case (q.st)
      SQ_IDLE:
      begin
        // Commands while running are ignored
        if (req.start)
        begin
          d.st = SQ_RUN;
          d.idx = '0;
          d.wend = 1'b0;
          d.first = 1'b1;
          d.wr.sel = req.sel;
          d.wr.addr = req.addr;
          d.wr.data = req.data;
          // Reset mode loads the unassigned code everywhere
          d.wr.code = (mode == MD_CM_RESET) ? CODE_UNASSIGNED : req.code;
          d.walk = (mode == MD_CM_RESET) || (mode == MD_TEST) ||
                   ((mode == MD_NORMAL) && req.full_field);
          case (mode)
            MD_CM_RESET: d.cnt = CYC_CMR - 1'b1;
            MD_INIT: d.cnt = CYC_INIT - 1'b1;
            MD_TEST: d.cnt = CYC_TEST - 1'b1;
            default: d.cnt = req.full_field ? CYC_TRI - 1'b1 : CYC_NORM - 1'b1;
          endcase
        end
      end
      SQ_RUN:
      begin
        d.first = 1'b0;
        if (q.walk)
        begin
          // One location per cycle, address register ignored
          d.wr.we = !q.wend;
          d.wr.addr = q.idx;
          d.idx = q.idx + 1'b1;
          d.wend = q.wend || (q.idx == WALK_LAST);
        end
        else
        begin
          // Single location at the access address
          d.wr.we = q.first;
        end
        if (q.cnt == '0)
        begin
          d.st = SQ_IDLE;
          d.done = 1'b1;
        end
        else
        begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default:
      begin
        d.st = SQ_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  // Outputs
  assign busy = (q.st == SQ_RUN);
  assign done = q.done;
  assign wr = q.wr;

endmodule

// [swm_ctrl.sv]
// Interrupt mask and operation mode control of the time-slot switching unit
`timescale 1ns/1ps
module swm_ctrl #(
  parameter int LANES = 4,
  parameter int IRQ_N = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire swm_pkg::swm_bus_t bus,
  output logic [swm_pkg::DW-1:0] rdata,
  // Interrupt sources and output
  input wire logic [IRQ_N-1:0] irq_evt,
  input wire logic sq_flag,
  output logic int_n,
  // Memory access
  input wire swm_pkg::swm_acc_req_t acc_req,
  output logic acc_busy,
  output logic acc_done,
  output swm_pkg::swm_cm_wr_t cm_wr,
  output logic switching_on,
  // PCM interface
  input wire logic [LANES-1:0] pcm_tx_i,
  input wire logic [LANES-1:0] pcm_tri_i,
  input wire logic [LANES-1:0] pcm_rx_i,
  output logic [LANES-1:0] pcm_tx_o,
  output logic [LANES-1:0] pcm_tx_oe,
  output logic [LANES-1:0] tsc_n_o,
  output logic [LANES-1:0] pcm_rx_o,
  // Subscriber interface
  input wire logic [LANES-1:0] sub_data_i,
  input wire logic sub_clk_i,
  input wire logic sub_fsc_i,
  output logic [LANES-1:0] sub_data_o,
  output logic [LANES-1:0] sub_data_oe,
  output logic sub_clk_o,
  output logic sub_clk_oe,
  output logic sub_fsc_o,
  output logic sub_fsc_oe,
  // Monitor channel
  output logic mon_hs_en
);
  import swm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  // Status and mask are one register byte
  if (IRQ_N != DW)
  begin : g_chk_irq
    $error("swm_ctrl: IRQ_N must equal the register width");
  end
  // At least one line per interface
  if (LANES < 1)
  begin : g_chk_lanes
    $error("swm_ctrl: LANES must be at least one");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [DW-1:0] mask; // Interrupt mask, one blocks
    swm_omr_t omr; // Operation mode register
    logic [DW-1:0] pend; // Sticky event store
    logic [DW-1:0] rdata; // Registered read data
    logic int_n; // Interrupt output, active low
    logic [1:0] gap; // Forced inactive cycles left
  } swm_ctrl_st_t;

  swm_ctrl_st_t q, d;

  // Bus decode helpers
  logic [AW-1:0] eff_addr; // Address after bank select
  logic wr_stb; // Write strobe this cycle
  logic rd_stb; // Read strobe this cycle
  logic sel_mask; // Mask or status address hit
  logic sel_mode; // Mode register address hit

  // Interrupt helpers
  logic [DW-1:0] status_view; // Status as the host reads it
  logic [DW-1:0] rd_clr; // Bits cleared by a status read
  logic [DW-1:0] evt_in; // Events without the level flag
  logic unmasked_pend; // Unmasked interrupt pending now

  // Mode helpers
  logic if_run; // Interfaces operational
  logic pcm_on; // PCM outputs active
  logic sub_on; // Subscriber outputs active

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode
  always_comb
  begin
    eff_addr = bus.addr;
    // Bank select only applies on the demultiplexed bus
    if (!bus.mux_mode)
    begin
      eff_addr[BANK_BIT] = bus.addr[BANK_BIT] | q.omr.bank_select;
    end
    wr_stb = !bus.cs_n && !bus.wr_n;
    rd_stb = !bus.cs_n && !bus.rd_n;
    if (bus.mux_mode)
    begin
      sel_mask = (eff_addr == ADR_M_MASK);
      sel_mode = (eff_addr == ADR_M_MODE_A) || (eff_addr == ADR_M_MODE_B);
    end
    else
    begin
      sel_mask = (eff_addr == ADR_D_MASK);
      sel_mode = (eff_addr == ADR_D_MODE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status view
  always_comb
  begin
    // Masked events stay hidden until the mask is released
    status_view = q.pend & ~q.mask;
    // Queue flag is a level and shows regardless of the mask
    status_view[SQ_BIT] = sq_flag;
    // Output only sees unmasked bits, queue flag included
    unmasked_pend = |(status_view & ~q.mask);
    // A read clears what it showed; hidden events survive
    rd_clr = (rd_stb && sel_mask) ? status_view : '0;
    rd_clr[SQ_BIT] = 1'b0;
    evt_in = irq_evt;
    // Queue flag is not latched, it follows the queue
    evt_in[SQ_BIT] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    d = q;
    // New events win over a clear in the same cycle
    d.pend = (q.pend & ~rd_clr) | evt_in;
    // Gap counter runs down to zero
    if (q.gap != '0)
    begin
      d.gap = q.gap - 1'b1;
    end
    // Register writes
    if (wr_stb && sel_mask)
    begin
      d.mask = bus.wdata;
      // Pulse the output inactive so an edge-triggered host sees a new edge
      if (unmasked_pend)
      begin
        d.gap = INT_GAP_CYC;
      end
    end
    if (wr_stb && sel_mode)
    begin
      // Takes effect at once, no further command needed
      d.omr = swm_omr_t'(bus.wdata);
    end
    // Register reads
    if (rd_stb)
    begin
      if (sel_mask)
        d.rdata = status_view;
      else if (sel_mode)
        d.rdata = q.omr;
      else
        d.rdata = RD_UNMAPPED;
    end
    // Interrupt output, held inactive during the gap
    d.int_n = !(unmasked_pend && (d.gap == '0));
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q.mask <= RST_MASK;
      q.omr <= swm_omr_t'(RST_MODE);
      q.pend <= RST_STATUS;
      q.rdata <= RD_UNMAPPED;
      q.int_n <= 1'b1;
      q.gap <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign int_n = q.int_n;

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  always_comb
  begin
    // Normal and test modes run the interfaces; reset and init do not
    if_run = (q.omr.mode_field == MD_NORMAL) || (q.omr.mode_field == MD_TEST);
    pcm_on = if_run && q.omr.pcm_standby_bit;
    sub_on = if_run && q.omr.subscriber_standby_bit;
  end

  // Switching runs only in operational modes
  assign switching_on = if_run;
  // Handshake follows its select bit directly
  assign mon_hs_en = q.omr.monitor_protocol_select;

  ////////////////////////////////////////////////////////////////////////////
  // PCM interface
  always_comb
  begin
    // Upstream memory data always reach the pins
    pcm_tx_o = pcm_tx_i;
    if (pcm_on)
    begin
      // Tristate field decides per line, one floats
      pcm_tx_oe = ~pcm_tri_i;
      tsc_n_o = pcm_tri_i;
    end
    else
    begin
      // Standby: float data, control pins inactive high
      pcm_tx_oe = '0;
      tsc_n_o = '1;
    end
    // Loop: transmit drives receive, line data ignored
    if (q.omr.pcm_test_loop_bit)
      pcm_rx_o = pcm_tx_i;
    else
      pcm_rx_o = pcm_rx_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Subscriber interface
  always_comb
  begin
    sub_clk_o = sub_clk_i;
    sub_fsc_o = sub_fsc_i;
    // Clock and frame sync float in standby
    sub_clk_oe = sub_on;
    sub_fsc_oe = sub_on;
    if (q.omr.subscriber_driver_select)
    begin
      // Open drain: drive low only, needs external pull-up
      sub_data_o = '0;
      sub_data_oe = sub_on ? ~sub_data_i : '0;
    end
    else
    begin
      // Push-pull with tristate
      sub_data_o = sub_data_i;
      sub_data_oe = sub_on ? '1 : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory access sequencer
  // The host should clear the memory in reset mode after every reset
  swm_seq #(
    .WALK_LEN(2 ** CM_AW)
  ) u_seq (
    .clk(clk),
    .rstn(rstn),
    .req(acc_req),
    .mode(q.omr.mode_field),
    .busy(acc_busy),
    .done(acc_done),
    .wr(cm_wr)
  );

endmodule

// [swm_ctrl_asserts.sv]
// Concurrent checks on the ports of the mask and mode control block
`timescale 1ns/1ps
module swm_ctrl_asserts #(
  parameter int LANES = 4,
  parameter int IRQ_N = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register bus and interrupt
  input wire swm_pkg::swm_bus_t bus,
  input wire logic int_n,
  // Memory access
  input wire swm_pkg::swm_acc_req_t acc_req,
  input wire logic acc_busy,
  input wire logic acc_done,
  input wire swm_pkg::swm_cm_wr_t cm_wr,
  input wire logic switching_on,
  // PCM pins
  input wire logic [LANES-1:0] pcm_tx_i,
  input wire logic [LANES-1:0] pcm_tri_i,
  input wire logic [LANES-1:0] pcm_rx_i,
  input wire logic [LANES-1:0] pcm_tx_o,
  input wire logic [LANES-1:0] pcm_tx_oe,
  input wire logic [LANES-1:0] tsc_n_o,
  input wire logic [LANES-1:0] pcm_rx_o,
  // Subscriber pins and monitor
  input wire logic [LANES-1:0] sub_data_i,
  input wire logic [LANES-1:0] sub_data_o,
  input wire logic [LANES-1:0] sub_data_oe,
  input wire logic sub_clk_oe,
  input wire logic mon_hs_en
);
  import swm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Shadow mode register; kept here since the demux map moves with bank select
  swm_omr_t mode_q;
  swm_omr_t mode_d;
  logic wr_hit; // Write strobe taken this edge
  logic mask_wr; // Write lands on the mask
  logic [AW-1:0] eff_addr; // Demux address with bank bit ORed in
  // Decode and next value
  always_comb
  begin
    wr_hit = !bus.cs_n && !bus.wr_n;
    eff_addr = bus.addr | {1'b0, mode_q.bank_select, 4'h0};
    mask_wr = wr_hit && (bus.mux_mode ? bus.addr == ADR_M_MASK : eff_addr == ADR_D_MASK);
    mode_d = mode_q;
    if (wr_hit && (bus.mux_mode ? (bus.addr == ADR_M_MODE_A || bus.addr == ADR_M_MODE_B)
        : eff_addr == ADR_D_MODE))
      mode_d = swm_omr_t'(bus.wdata);
  end
  // Register, same reset value as the device
  always_ff @(posedge clk)
  begin
    if (!rstn)
      mode_q <= swm_omr_t'(RST_MODE);
    else
      mode_q <= mode_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Accepted access start in a given mode
  sequence s_go(swm_mode_t m);
    acc_req.start && !acc_busy && mode_q.mode_field == m;
  endsequence
  // First write of an access, two edges after the start
  sequence s_first_we;
    ##2 cm_wr.we;
  endsequence

  AST_CMR_TIME: assert property (s_go(MD_CM_RESET) |-> ##1 acc_busy ##256 acc_done)
    else $error("memory reset access not 256 cycles");
  AST_CMR_FILL: assert property (s_go(MD_CM_RESET) |-> s_first_we ##0
    (cm_wr.code == CODE_UNASSIGNED && cm_wr.data == $past(acc_req.data, 2)))
    else $error("memory reset fill values wrong");
  AST_INIT_TIME: assert property (s_go(MD_INIT) |-> ##3 acc_done)
    else $error("init access not 2 cycles");
  AST_INIT_WE: assert property (s_go(MD_INIT) |-> s_first_we ##0
    cm_wr.addr == $past(acc_req.addr, 2))
    else $error("init access address wrong");
  AST_NORM_TIME: assert property (s_go(MD_NORMAL) ##0 !acc_req.full_field |-> ##10 acc_done)
    else $error("normal access not 9 cycles");
  AST_OFF_PINS: assert property (!mode_q.mode_field[0] |->
    pcm_tx_oe == '0 && sub_data_oe == '0 && !sub_clk_oe && !switching_on)
    else $error("interfaces active while out of operation");
  AST_PSB_LOW: assert property (!mode_q.pcm_standby_bit |-> pcm_tx_oe == '0 && tsc_n_o == '1)
    else $error("transmit not floated in standby");
  AST_PSB_HIGH: assert property (mode_q.pcm_standby_bit && mode_q.mode_field[0] |->
    pcm_tx_oe == ~pcm_tri_i && pcm_tx_o == pcm_tx_i)
    else $error("transmit not under tristate field");
  AST_LOOP: assert property (mode_q.mode_field[0] |->
    pcm_rx_o == (mode_q.pcm_test_loop_bit ? pcm_tx_o : pcm_rx_i))
    else $error("receive path selection wrong");
  AST_OPEN_DRAIN: assert property (mode_q.mode_field[0] && mode_q.subscriber_standby_bit &&
    mode_q.subscriber_driver_select |-> sub_data_o == '0 && sub_data_oe == ~sub_data_i)
    else $error("open drain drive wrong");
  AST_SUB_SB: assert property (!mode_q.subscriber_standby_bit |-> sub_data_oe == '0)
    else $error("subscriber outputs driven in standby");
  AST_MON: assert property (mon_hs_en == mode_q.monitor_protocol_select)
    else $error("monitor handshake enable wrong");
  AST_MASK_GAP: assert property (mask_wr && !int_n |-> ##[1:2] int_n)
    else $error("no interrupt gap after mask write");
endmodule

bind swm_ctrl swm_ctrl_asserts #(.LANES(LANES), .IRQ_N(IRQ_N)) u_asserts (
  .clk(clk), .rstn(rstn), .bus(bus), .int_n(int_n), .acc_req(acc_req),
  .acc_busy(acc_busy), .acc_done(acc_done), .cm_wr(cm_wr), .switching_on(switching_on),
  .pcm_tx_i(pcm_tx_i), .pcm_tri_i(pcm_tri_i), .pcm_rx_i(pcm_rx_i), .pcm_tx_o(pcm_tx_o),
  .pcm_tx_oe(pcm_tx_oe), .tsc_n_o(tsc_n_o), .pcm_rx_o(pcm_rx_o), .sub_data_i(sub_data_i),
  .sub_data_o(sub_data_o), .sub_data_oe(sub_data_oe), .sub_clk_oe(sub_clk_oe),
  .mon_hs_en(mon_hs_en));

// [swm_host.sv]
// Host model running register cycles on the parallel bus
`timescale 1ns/1ps
module swm_host (
  // Clock
  input wire logic clk,
  // Bus to the block
  output swm_pkg::swm_bus_t bus,
  input wire logic [swm_pkg::DW-1:0] rdata
);
  import swm_pkg::*;

  // Idle bus from time zero, strobes high
  initial bus = '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, mux_mode: 1'b0, addr: '0, wdata: '0};

  ////////////////////////////////////////////////////////////////////////////
  // One access held over exactly one taking edge, map chosen by mux
  task automatic access(input logic wr, input logic mux, input logic [AW-1:0] a,
    input logic [DW-1:0] d, output logic [DW-1:0] q);
  begin
    @(posedge clk);
    bus <= '{cs_n: 1'b0, wr_n: !wr, rd_n: wr, mux_mode: mux, addr: a, wdata: d};
    @(posedge clk);
    // Released lines change pattern so stale values are never trusted
    bus <= '{cs_n: 1'b1, wr_n: 1'b1, rd_n: 1'b1, mux_mode: mux, addr: ~a, wdata: ~d};
    #1;
    q = rdata;
  end
  endtask
endmodule

// [swm_ctrl_tb.sv]
// Self-checking testbench of the switch mask and mode control block
`timescale 1ns/1ps
module swm_ctrl_tb;
  import swm_pkg::*;

  // Expected pin picture for one mode value
  typedef struct packed {
    logic [7:0] mode;
    logic sw;
    logic mon;
    logic [3:0] oe;
    logic [3:0] tristate_control_pin;
    logic [3:0] soe;
    logic [3:0] rx;
  } swm_row_t;
  // Fixed pin inputs: tristate 3, transmit 6, receive 9, subscriber 5
  localparam swm_row_t ROWS [5] = '{'{8'h00, 1'b0, 1'b0, 4'h0, 4'hf, 4'h0, 4'h9},
    '{8'hfe, 1'b1, 1'b1, 4'hc, 4'h3, 4'ha, 4'h6}, '{8'hc2, 1'b1, 1'b0, 4'h0, 4'hf, 4'hf, 4'h9},
    '{8'h64, 1'b1, 1'b1, 4'hc, 4'h3, 4'h0, 4'h9}, '{8'ha6, 1'b0, 1'b1, 4'h0, 4'hf, 4'h0, 4'h9}};

  ////////////////////////////////////////////////////////////////////////////
  logic clk = 1'b0;
  logic rstn = 1'b0;
  swm_bus_t bus;
  logic [DW-1:0] rdata, rd_data;
  logic [7:0] irq_evt = '0;
  logic sq_flag = 1'b0;
  logic int_n, acc_busy, acc_done, switching_on, mon_hs_en;
  swm_acc_req_t acc_req = '0;
  swm_cm_wr_t cm_wr;
  logic [3:0] pcm_tx_o, pcm_tx_oe, tsc_n_o, pcm_rx_o, sub_data_o, sub_data_oe;
  logic sub_clk_i = 1'b0;
  int failures = 0;
  int tests_run = 0;
  int we_cnt = 0;
  logic [7:0] we_addr;
  int n;
  logic seen;

  always #12.5 clk = ~clk;
  // Toggling subscriber clock input
  always @(posedge clk) sub_clk_i <= ~sub_clk_i;
  // Count memory writes and keep the last address
  always @(posedge clk)
    if (cm_wr.we === 1'b1)
    begin
      we_cnt <= we_cnt + 1;
      we_addr <= cm_wr.addr;
    end

  swm_host host (.clk(clk), .bus(bus), .rdata(rdata));
  swm_ctrl uut (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .irq_evt(irq_evt),
    .sq_flag(sq_flag), .int_n(int_n), .acc_req(acc_req), .acc_busy(acc_busy),
    .acc_done(acc_done), .cm_wr(cm_wr), .switching_on(switching_on), .pcm_tx_i(4'h6),
    .pcm_tri_i(4'h3), .pcm_rx_i(4'h9), .pcm_tx_o(pcm_tx_o), .pcm_tx_oe(pcm_tx_oe),
    .tsc_n_o(tsc_n_o), .pcm_rx_o(pcm_rx_o), .sub_data_i(4'h5), .sub_clk_i(sub_clk_i),
    .sub_fsc_i(1'b1), .sub_data_o(sub_data_o), .sub_data_oe(sub_data_oe), .sub_clk_o(),
    .sub_clk_oe(), .sub_fsc_o(), .sub_fsc_oe(), .mon_hs_en(mon_hs_en));

  ////////////////////////////////////////////////////////////////////////////
  // Compare tasks: register or pin value, and counts
  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp, input string what);
  begin
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  end
  endtask
  task automatic chk_cnt(input int got, input int exp, input string what);
  begin
    tests_run++;
    if (got != exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  end
  endtask
  // One interrupt event pulse
  task automatic pulse(input logic [7:0] v);
  begin
    @(posedge clk);
    irq_evt <= v;
    @(posedge clk);
    irq_evt <= '0;
    repeat (2) @(posedge clk);
    #1;
  end
  endtask
  // Memory access in one mode; returns writes seen and cycles to done
  task automatic run_acc(input logic [7:0] mode, input logic full);
  begin
    host.access(1'b1, 1'b0, ADR_D_MODE, mode, rd_data);
    we_cnt = 0;
    @(posedge clk);
    acc_req <= '{start: 1'b1, sel: 1'b0, full_field: full, addr: 8'h33, code: 4'h5, data: 8'h5a};
    @(posedge clk);
    acc_req.start <= 1'b0;
    n = 0;
    // Bounded wait for the done pulse
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (acc_done !== 1'b1 && n < 3000);
    // Last memory write is counted one edge later
    @(posedge clk);
    #1;
  end
  endtask
  task automatic wrap_up;
  begin
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Watchdog, several times the expected run of about 3500 cycles
  initial
  begin
    #400000;
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Reset values
    host.access(1'b0, 1'b0, ADR_D_MODE, 8'h00, rd_data);
    chk_val(rd_data, RST_MODE, "mode reset");
    host.access(1'b0, 1'b0, ADR_D_MASK, 8'h00, rd_data);
    chk_val(rd_data, RST_STATUS, "status reset");
    chk_val(int_n, 1'b1, "int idle");
    // Memory reset first after hardware reset, then every mode
    run_acc(8'h00, 1'b0);
    chk_cnt(n, 256, "reset time");
    chk_cnt(we_cnt, 256, "reset writes");
    run_acc(8'h80, 1'b0);
    chk_cnt(n, 2, "init time");
    chk_val(we_addr, 8'h33, "init addr");
    run_acc(8'hc0, 1'b0);
    chk_cnt(n, 9, "normal time");
    chk_cnt(we_cnt, 1, "normal writes");
    run_acc(8'hc0, 1'b1);
    chk_cnt(n, 1035, "field time");
    run_acc(8'h40, 1'b0);
    chk_cnt(n, 2057, "test time");
    chk_cnt(we_cnt, 256, "test writes");
    $display("test memory access done");
    // Mode rows
    foreach (ROWS[i])
    begin
      host.access(1'b1, 1'b0, ADR_D_MODE, ROWS[i].mode, rd_data);
      host.access(1'b0, 1'b0, ADR_D_MODE, 8'h00, rd_data);
      chk_val(rd_data, ROWS[i].mode, "mode readback");
      chk_val(switching_on, ROWS[i].sw, "switching");
      chk_val(pcm_tx_oe, ROWS[i].oe, "tx enable");
      chk_val(tsc_n_o, ROWS[i].tristate_control_pin, "tristate ctrl");
      chk_val(sub_data_oe, ROWS[i].soe, "sub enable");
      chk_val(mon_hs_en, ROWS[i].mon, "monitor");
      if (ROWS[i].sw)
        chk_val(pcm_rx_o, ROWS[i].rx, "receive");
    end
    $display("test mode rows done");
    // Bank select moves the demux map; unmapped reads give zero
    host.access(1'b1, 1'b0, ADR_D_MODE, 8'h01, rd_data);
    host.access(1'b0, 1'b0, ADR_D_MODE, 8'h00, rd_data);
    chk_val(rd_data, RD_UNMAPPED, "bank hides mode");
    host.access(1'b0, 1'b1, ADR_M_MODE_B, 8'h00, rd_data);
    chk_val(rd_data, 8'h01, "mux mode read");
    host.access(1'b1, 1'b1, ADR_M_MODE_A, 8'hc2, rd_data);
    host.access(1'b0, 1'b0, 6'h05, 8'h00, rd_data);
    chk_val(rd_data, RD_UNMAPPED, "unmapped");
    $display("test address map done");
    // Masked event is held and shown on release
    host.access(1'b1, 1'b1, ADR_M_MASK, 8'h80, rd_data);
    pulse(8'h80);
    chk_val(int_n, 1'b1, "masked int");
    host.access(1'b1, 1'b1, ADR_M_MASK, 8'h00, rd_data);
    @(posedge clk);
    #1;
    chk_val(int_n, 1'b0, "released int");
    host.access(1'b0, 1'b1, ADR_M_MASK, 8'h00, rd_data);
    chk_val(rd_data, 8'h80, "released status");
    // Mask write with a pending unmasked event gives a short gap
    pulse(8'h01);
    chk_val(int_n, 1'b0, "pending int");
    host.access(1'b1, 1'b0, ADR_D_MASK, 8'h02, rd_data);
    seen = int_n;
    repeat (2)
    begin
      @(posedge clk);
      #1;
      seen = seen | int_n;
    end
    chk_val(seen, 1'b1, "mask write gap");
    repeat (3) @(posedge clk);
    #1;
    chk_val(int_n, 1'b0, "int back");
    host.access(1'b0, 1'b0, ADR_D_MASK, 8'h00, rd_data);
    chk_val(rd_data, 8'h01, "gap status");
    // Masked signaling flag shows without interrupt
    host.access(1'b1, 1'b1, ADR_M_MASK, 8'h40, rd_data);
    sq_flag <= 1'b1;
    pulse(8'h00);
    chk_val(int_n, 1'b1, "masked flag int");
    host.access(1'b0, 1'b1, ADR_M_MASK, 8'h00, rd_data);
    chk_val(rd_data, 8'h40, "masked flag status");
    host.access(1'b1, 1'b1, ADR_M_MASK, 8'h00, rd_data);
    pulse(8'h00);
    chk_val(int_n, 1'b0, "flag int");
    sq_flag <= 1'b0;
    $display("test interrupts done");
    // Reset in mid-run restores the mode register
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    host.access(1'b0, 1'b0, ADR_D_MODE, 8'h00, rd_data);
    chk_val(rd_data, RST_MODE, "mode after reset");
    $display("test second reset done");
    wrap_up();
  end
endmodule
